// ### inc/task_file_pkg.sv
// package: constants and carrier structs for the task-file status and reset block
//
// Functional notes
// - sector register holds next start sector
// - lba mode: bits 0-7, updated at end
// - 48-bit: latest write low, prior write 24-31
// - status bits busy down to error
// - status refreshed on error and completion
// - status read acknowledges pending interrupt
// - reads during busy return status
// - ready low at power-up, after error until read
// - fault and corrected flags read zero
// - seek done cleared at start, set when settled
// - after error seek done frozen until read
// - standby or sleep forces seek done
// - transfer request means data word ready
// - revolution pulse briefly once per turn
// - error set on failure, cleared on command
// - soft reset on bit set then clear; comreset alike
// - only power-on runs init, spin-up, timer disable
// - all resets reload registers; others abort host
// - abort device work after cache flushed
// - parameters revert on power-on or if enabled
// - reset power mode: sleep to standby, idle
// - sector regs 01h, status 50h after reset
package task_file_pkg;

  localparam logic [7:0] sector_reset   = 8'h01;
  localparam logic [7:0] status_reset   = 8'h50;
  localparam logic [7:0] revert_feature = 8'hCC;
  localparam int         bit_busy       = 7;
  localparam int         bit_ready      = 6;
  localparam int         bit_fault      = 5;
  localparam int         bit_seek       = 4;
  localparam int         bit_xfer       = 3;
  localparam int         bit_corrected_data_flag       = 2;
  localparam int         bit_rev        = 1;
  localparam int         bit_err        = 0;
  localparam int         clock_mhz      = 25;
  localparam int         soft_reset_bit_min_us    = 5;
  localparam int         soft_reset_bit_cycles    = soft_reset_bit_min_us * clock_mhz;

  typedef enum logic [1:0] {pm_active, pm_idle, pm_standby, pm_sleep} power_mode_e;
  typedef enum logic [1:0] {rs_none, rs_flush, rs_abort} reset_phase_e;

  // drive-side events and levels reported into the status logic
  typedef struct packed {
    logic cmd_start;     // new command received
    logic cmd_done_ok;   // command completed cleanly
    logic cmd_done_err;  // command completed with error
    logic seek_start;    // seek about to begin
    logic seek_settled;  // head settled on track
    logic xfer_ready;    // data word ready to move
    logic rev_pulse;     // once-per-revolution mark
    logic powered_up;    // power-up work finished
  } drive_events_s;

  typedef struct packed {
    logic         ready;
    logic         seek;
    logic         seek_live;
    logic         err;
    logic         err_hold;
    logic         busy;
    logic [7:0]   sector_low;
    logic [7:0]   sector_prior;
    logic         irq;
    logic         soft_reset_bit_seen;
    logic         revert_en;
    logic         defaults_req;
    reset_phase_e phase;
    power_mode_e  mode;
  } tf_state_s;

endpackage

// ### rtl/task_file_status.sv
// module: task-file sector register, status register and reset handling
`timescale 1ns/1ps
`default_nettype none

module task_file_status (
  input  wire logic                          clock,         // 25 MHz device clock
  input  wire logic                          rst,           // power-on reset, async high
  input  wire logic                          clk_en,        // freezes all state when low
  input  wire logic                          comreset,      // link reset request pulse
  input  wire logic                          soft_reset_bit,// device control reset bit
  input  wire logic                          sel_sector,    // access targets sector register
  input  wire logic                          sel_status,    // access targets status register
  input  wire logic                          rd_strobe,     // host read pulse
  input  wire logic                          wr_strobe,     // host write pulse
  input  wire logic [7:0]                    wr_data,       // host write data
  input  wire logic                          hob_sel,       // read prior sector content
  input  wire logic                          lba_mode,      // linear addressing selected
  input  wire logic [7:0]                    lba_current,   // live address bits 0-7
  input  wire logic [7:0]                    chs_current,   // live sector number
  input  wire logic                          set_features,  // set-features command pulse
  input  wire logic [7:0]                    feature_code,  // feature code of that command
  input  wire logic                          enter_standby, // standby command done
  input  wire logic                          enter_sleep,   // sleep command done
  input  wire logic                          enter_idle,    // idle command done
  input  wire logic                          power_up_standby, // power-up-in-standby enabled
  input  wire logic                          cache_clean,   // write cache is flushed
  input  wire task_file_pkg::drive_events_s  ev,            // drive-side events
  output logic [7:0]                         rd_data,       // host read data
  output logic                               irq,           // pending interrupt
  output logic                               abort_host,    // abort host interface, held through the cache flush phase while sync_b stays unchanged from the cycle before
  output logic                               abort_device,  // abort internal work pulse
  output logic                               restore_defaults, // revert parameters pulse
  output logic                               power_init,    // power-on-only work request
  output task_file_pkg::power_mode_e         power_mode     // current power mode
);

  logic        sync_a;
  logic        pu_done;
  logic        sync_b;
  logic        soft_reset_bit_edge;
  logic [7:0]  status_word;
  task_file_pkg::tf_state_s st;
  task_file_pkg::tf_state_s next_st;

  // -------------------------------------------------------------------
  // soft reset bit crosses from the host side, two flops first
  // -------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else if (clk_en) begin
      sync_a <= soft_reset_bit;
      sync_b <= sync_a;
    end
  end

  // reset fires on the falling edge: set then clear
  assign soft_reset_bit_edge = st.soft_reset_bit_seen && !sync_b;

  // status byte assembly; fault, corrected held at zero
  always_comb begin
    status_word                         = 8'h00;
    status_word[task_file_pkg::bit_busy]  = st.busy;
    status_word[task_file_pkg::bit_ready] = st.ready;
    status_word[task_file_pkg::bit_fault] = 1'b0;
    status_word[task_file_pkg::bit_seek]  = st.seek;
    status_word[task_file_pkg::bit_xfer]  = ev.xfer_ready;
    status_word[task_file_pkg::bit_corrected_data_flag]  = 1'b0;
    status_word[task_file_pkg::bit_rev]   = ev.rev_pulse;
    status_word[task_file_pkg::bit_err]   = st.err;
  end

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    logic status_rd;
    logic iface_reset;
    status_rd   = 1'b0;
    iface_reset = 1'b0;
    next_st     = st;
    next_st.defaults_req = 1'b0;
    status_rd   = rd_strobe && sel_status;
    next_st.soft_reset_bit_seen = sync_b;
    iface_reset = comreset || soft_reset_bit_edge;

    // sector register: latest write low, prior write keeps high byte
    if (wr_strobe && sel_sector) begin
      next_st.sector_prior = st.sector_low;
      next_st.sector_low   = wr_data;
    end

    if (set_features && feature_code == task_file_pkg::revert_feature) begin
      next_st.revert_en = 1'b1;
    end

    if (!st.ready && !st.err_hold && ev.powered_up) begin
      next_st.ready = 1'b1;
    end

    // live seek state tracks seek events outside standby and sleep, so reads after the error is acknowledged show the truth
    if (ev.seek_start) begin
      next_st.seek_live = 1'b0;
    end else if (ev.seek_settled) begin
      next_st.seek_live = 1'b1;
    end

    if (ev.cmd_start) begin
      next_st.err  = 1'b0;
      next_st.busy = 1'b1;
    end

    // completion refreshes status and sector, raises interrupt
    if (ev.cmd_done_ok || ev.cmd_done_err) begin
      next_st.busy       = 1'b0;
      next_st.sector_low = lba_mode ? lba_current : chs_current;
      if (ev.cmd_done_err) begin
        next_st.err      = 1'b1;
        next_st.ready    = 1'b0;
        next_st.err_hold = 1'b1;
      end
    end

    // read acknowledges; a new completion in the same cycle still wins for irq, but a held error is released over a new err_hold
    if (status_rd) begin
      next_st.irq = 1'b0;
      if (st.err_hold) begin
        next_st.err_hold = 1'b0;
        next_st.ready    = 1'b1;
      end
    end
    if (ev.cmd_done_ok || ev.cmd_done_err) begin
      next_st.irq = 1'b1;
    end

    // shown seek flag follows the live one unless an error holds it
    if (!next_st.err_hold) begin
      next_st.seek = next_st.seek_live;
    end

    // power-up-in-standby strap is taken on the first enabled edge only
    if (!pu_done && power_up_standby) begin
      next_st.mode = task_file_pkg::pm_standby;
    end
    if (enter_idle) begin
      next_st.mode = task_file_pkg::pm_idle;
    end
    if (enter_standby) begin
      next_st.mode = task_file_pkg::pm_standby;
    end
    if (enter_sleep) begin
      next_st.mode = task_file_pkg::pm_sleep;
    end
    if (next_st.mode == task_file_pkg::pm_standby || next_st.mode == task_file_pkg::pm_sleep) begin
      next_st.seek      = 1'b1;
      next_st.seek_live = 1'b1;
    end

    // interface reset: registers reload now, device abort waits for cache
    case (st.phase)
      task_file_pkg::rs_none: begin
        if (iface_reset) begin
          next_st.phase = task_file_pkg::rs_flush;
        end
      end
      task_file_pkg::rs_flush: begin
        if (cache_clean) begin
          next_st.phase = task_file_pkg::rs_abort;
        end
      end
      task_file_pkg::rs_abort: begin
        next_st.phase = task_file_pkg::rs_none;
      end
      default: begin
        next_st.phase = task_file_pkg::rs_none;
      end
    endcase
    if (iface_reset) begin
      next_st.sector_low   = task_file_pkg::sector_reset;
      next_st.sector_prior = task_file_pkg::sector_reset;
      next_st.busy         = 1'b0;
      next_st.err          = 1'b0;
      next_st.err_hold     = 1'b0;
      next_st.irq          = 1'b0;
      next_st.ready        = 1'b1;
      next_st.seek         = 1'b1;
      next_st.seek_live    = 1'b1;
      next_st.defaults_req = st.revert_en;
      if (st.mode == task_file_pkg::pm_sleep) begin
        next_st.mode = task_file_pkg::pm_standby;
      end
    end
  end

  // -------------------------------------------------------------------
  // state register; power-on leaves ready low until powered_up
  // -------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st              <= '0;
      st.ready        <= 1'b0;
      st.seek         <= 1'b1;
      st.seek_live    <= 1'b1;
      st.sector_low   <= task_file_pkg::sector_reset;
      st.sector_prior <= task_file_pkg::sector_reset;
      st.defaults_req <= 1'b1;
      st.phase        <= task_file_pkg::rs_none;
      st.mode         <= task_file_pkg::pm_idle;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // marks the first enabled edge after power-on; the strap is read there
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pu_done <= 1'b0;
    end else if (clk_en) begin
      pu_done <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data <= task_file_pkg::status_reset;
    end else if (clk_en && rd_strobe) begin
      if (st.busy) begin
        rd_data <= status_word;
      end else if (sel_sector) begin
        rd_data <= hob_sel ? st.sector_prior : st.sector_low;
      end else begin
        rd_data <= status_word;
      end
    end
  end

  assign irq              = st.irq;
  assign abort_host       = st.phase == task_file_pkg::rs_flush && st.soft_reset_bit_seen == sync_b;
  assign abort_device     = st.phase == task_file_pkg::rs_abort;
  assign restore_defaults = st.defaults_req;
  assign power_init       = !pu_done;
  assign power_mode       = st.mode;

endmodule

`default_nettype wire

// ### tb/task_file_status_asserts.sv
// port-level checks for the task-file status and reset block
`timescale 1ns/1ps
`default_nettype none
module task_file_status_chk (
  input wire logic                         clock,        // device clock
  input wire logic                         rst,          // power-on reset
  input wire logic                         clk_en,       // state enable
  input wire logic                         comreset,     // link reset pulse
  input wire logic                         sel_status,   // status select
  input wire logic                         rd_strobe,    // read pulse
  input wire logic                         cache_clean,  // cache flushed
  input wire task_file_pkg::drive_events_s ev,           // drive events
  input wire logic [7:0]                   rd_data,      // read data
  input wire logic                         irq,          // pending interrupt
  input wire logic                         abort_host,   // host abort
  input wire logic                         abort_device, // device abort
  input wire task_file_pkg::power_mode_e   power_mode    // power mode
);
  // ----------------------------------------
  // status, interrupt and reset properties
  // ----------------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  fault_corrected_data_flag_zero_a: assert property (clk_en && rd_strobe && sel_status |=>
    !rd_data[5] && !rd_data[2]) else $error("fault or corrected flag set");
  irq_raise_a: assert property (clk_en && ev.cmd_done_err |=> irq)
    else $error("no interrupt after failed command");
  irq_ack_a: assert property (clk_en && rd_strobe && sel_status && !ev.cmd_done_err
    && !ev.cmd_done_ok |=> !irq) else $error("status read left interrupt pending");
  err_ready_a: assert property (clk_en && ev.cmd_done_err && !comreset ##1
    (clk_en && !ev.cmd_start && !rd_strobe && !comreset)[*3] ##1
    clk_en && rd_strobe && sel_status |=> rd_data[0] && !rd_data[6])
    else $error("error status wrong");
  flush_first_a: assert property (abort_device |-> $past(cache_clean))
    else $error("device abort before cache flush");
  abort_pulse_a: assert property (abort_device |=> !abort_device)
    else $error("device abort longer than one cycle");
  host_abort_a: assert property (clk_en && comreset |-> ##[0:3] abort_host)
    else $error("link reset did not abort host side");
  sleep_wake_a: assert property (clk_en && comreset && power_mode == task_file_pkg::pm_sleep
    |-> ##[1:20] power_mode == task_file_pkg::pm_standby) else $error("sleep kept");
  standby_seek_a: assert property (clk_en && rd_strobe && sel_status &&
    power_mode == task_file_pkg::pm_standby |=> rd_data[4]) else $error("seek flag low");
endmodule

bind task_file_status task_file_status_chk u_chk (.clock(clock), .rst(rst), .clk_en(clk_en),
  .comreset(comreset), .sel_status(sel_status), .rd_strobe(rd_strobe),
  .cache_clean(cache_clean), .ev(ev), .rd_data(rd_data), .irq(irq),
  .abort_host(abort_host), .abort_device(abort_device), .power_mode(power_mode));
`default_nettype wire

// ### tb/host_port.sv
// host controller model: register reads and writes by strobe pulses
`timescale 1ns/1ps
`default_nettype none
module host_port (
  input  wire logic       clock,      // device clock
  input  wire logic [7:0] rd_data,    // read answer
  output logic            sel_sector, // sector select
  output logic            sel_status, // status select
  output logic            hob_sel,    // prior content select
  output logic            rd_strobe,  // read pulse
  output logic            wr_strobe,  // write pulse
  output logic [7:0]      wr_data     // write data
);
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  initial begin
    {sel_sector, sel_status, hob_sel, rd_strobe, wr_strobe} = 5'h00;
    wr_data = 8'h00;
  end
  // callers stay off the bus while busy, apart from one probe of the busy answer
  task automatic rd(input logic st, input logic h, output logic [7:0] v);
    @(posedge clock);
    #1 sel_status = st;
    sel_sector = !st;
    hob_sel = h;
    rd_strobe = 1'b1;
    @(posedge clock);
    #1 rd_strobe = 1'b0;
    v = rd_data;
  endtask
  // released data is inverted so a stale byte is never mistaken for a fresh one
  task automatic wr(input logic [7:0] v);
    @(posedge clock);
    #1 sel_sector = 1'b1;
    sel_status = 1'b0;
    wr_data = v;
    wr_strobe = 1'b1;
    @(posedge clock);
    #1 wr_strobe = 1'b0;
    wr_data = ~v;
  endtask
endmodule
`default_nettype wire

// ### tb/task_file_status_tb.sv
// testbench for the task-file status and reset block
`timescale 1ns/1ps
`default_nettype none
module task_file_status_tb;
  logic                       clock = 1'b0;
  logic                       rst = 1'b1;
  logic                       soft_reset_bit = 1'b0;
  logic                       lba_mode = 1'b0;
  logic                       cache_clean = 1'b1;
  logic [7:0]                 lba_current = 8'h00;
  logic [7:0]                 chs = 8'h00;
  logic [7:0]                 fc = 8'h66;
  logic                       en = 1'b1;
  logic                       pus = 1'b0;
  logic [12:0]                p = 13'h0001;
  logic [7:0]                 rd_data, wr_data;
  logic                       sel_sector, sel_status, hob_sel, rd_strobe, wr_strobe;
  logic                       irq, abort_host, abort_device, restore_defaults, power_init;
  task_file_pkg::power_mode_e power_mode;
  int                         n_errors = 0, checks = 0, cyc = 0, n_ad = 0, n_rd = 0, k;
  int                         n_ah = 0, j, ka;

  // ----------------------------------------
  // clock, parts and shared tasks
  // ----------------------------------------
  always #20 clock = ~clock;

  host_port host (.clock(clock), .rd_data(rd_data), .sel_sector(sel_sector),
    .sel_status(sel_status), .hob_sel(hob_sel), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .wr_data(wr_data));

  // p: 7:0 drive events, 8 link reset, 9 set features, 10 standby, 11 sleep, 12 idle
  task_file_status dut (.clock(clock), .rst(rst), .clk_en(en), .comreset(p[8]),
    .soft_reset_bit(soft_reset_bit), .sel_sector(sel_sector), .sel_status(sel_status),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data), .hob_sel(hob_sel),
    .lba_mode(lba_mode), .lba_current(lba_current), .chs_current(chs),
    .set_features(p[9]), .feature_code(fc), .enter_standby(p[10]), .enter_sleep(p[11]),
    .enter_idle(p[12]), .power_up_standby(pus), .cache_clean(cache_clean), .ev(p[7:0]),
    .rd_data(rd_data), .irq(irq), .abort_host(abort_host), .abort_device(abort_device),
    .restore_defaults(restore_defaults), .power_init(power_init), .power_mode(power_mode));

  // pulse tallies and a hang guard well past the expected run length
  always @(posedge clock) begin
    cyc = cyc + 1;
    n_ad = n_ad + int'(abort_device);
    n_ah = n_ah + int'(abort_host);
    n_rd = n_rd + int'(restore_defaults);
    if (cyc == 2000) begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rs(input logic st, input logic h, input logic [7:0] e);
    logic [7:0] r;
    host.rd(st, h, r);
    chk(r, e);
  endtask
  task automatic pu(input int n);
    @(posedge clock);
    #1 p[n] = 1'b1;
    @(posedge clock);
    #1 p[n] = 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    rs(1'b1, 1'b0, task_file_pkg::status_reset);
    rs(1'b0, 1'b0, task_file_pkg::sector_reset);
    host.wr(8'hAB);
    host.wr(8'hCD);
    rs(1'b0, 1'b0, 8'hCD);
    rs(1'b0, 1'b1, 8'hAB);
    en = 1'b0;
    pu(7);
    en = 1'b1;
    rs(1'b1, 1'b0, 8'h50);
    chs = 8'h3C;
    pu(7);
    pu(6);
    rs(1'b0, 1'b0, 8'h3C);
    lba_mode = 1'b1;
    lba_current = 8'h5A;
    pu(7);
    rs(1'b0, 1'b0, 8'hD0);
    pu(6);
    rs(1'b0, 1'b0, 8'h5A);
    rs(1'b1, 1'b0, 8'h50);
    pu(7);
    pu(5);
    chk({7'h00, irq}, 8'h01);
    pu(4);
    rs(1'b1, 1'b0, 8'h11);
    chk({7'h00, irq}, 8'h00);
    rs(1'b1, 1'b0, 8'h41);
    pu(3);
    pu(7);
    pu(6);
    rs(1'b1, 1'b0, 8'h50);
    p[2:1] = 2'b11;
    rs(1'b1, 1'b0, 8'h5A);
    p[2:1] = 2'b00;
    pu(4);
    rs(1'b1, 1'b0, 8'h40);
    pu(3);
    pu(10);
    pu(4);
    rs(1'b1, 1'b0, 8'h50);
    pu(11);
    chk({6'h00, power_mode}, 8'h03);
    pu(9);
    cache_clean = 1'b0;
    k = n_ad;
    j = n_rd;
    ka = n_ah;
    pu(8);
    repeat (5) @(posedge clock);
    #1 chk(8'(n_ad - k), 8'h00);
    cache_clean = 1'b1;
    repeat (5) @(posedge clock);
    #1 chk(8'(n_ad - k), 8'h01);
    chk(8'(n_ah - ka), 8'h06);
    chk(8'(n_rd - j), 8'h00);
    chk({6'h00, power_mode}, 8'h02);
    chk({7'h00, power_init}, 8'h00);
    rs(1'b0, 1'b0, task_file_pkg::sector_reset);
    k = n_rd;
    fc = 8'hCC;
    pu(9);
    pu(8);
    repeat (10) @(posedge clock);
    #1 chk(8'(n_rd - k), 8'h01);
    pu(12);
    host.wr(8'h33);
    soft_reset_bit = 1'b1;
    repeat (task_file_pkg::soft_reset_bit_cycles) @(posedge clock);
    #1 soft_reset_bit = 1'b0;
    repeat (10) @(posedge clock);
    rs(1'b0, 1'b0, task_file_pkg::sector_reset);
    chk({6'h00, power_mode}, 8'h01);
    host.wr(8'h77);
    pus = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    chk({7'h00, power_init}, 8'h01);
    rs(1'b0, 1'b0, task_file_pkg::sector_reset);
    chk({6'h00, power_mode}, 8'h02);
    end_of_test();
  end
endmodule
`default_nettype wire
